// file: hdl/power_mode_ctrl.sv
// power-mode sequencing and output-buffer configuration with register port
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "power_cfg_params.svh"

module power_mode_ctrl #(
    parameter int CHANNELS        = 4,                    // converter channels
    parameter int DEEP_WAKE_CYCLES = (`DEEP_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input  wire logic                      clk,                // 125 MHz clock
    input  wire logic                      rst_b,              // async reset, active low
    input  wire logic                      clk_en,             // freezes all state except the reset synchronizer when low
    input  wire logic [7:0]                reg_addr,           // register address
    input  wire logic [15:0]               reg_wdata,          // write data
    input  wire logic                      reg_wr,             // write strobe
    input  wire logic                      reg_rd,             // read strobe
    output logic      [15:0]               reg_rdata,          // read data, cycle after strobe
    input  wire logic                      idle_request_pin,   // external idle request
    output logic      [CHANNELS-1:0]       chan_sleep,         // per-channel sleep
    output logic                           ref_power_on,       // reference powered
    output logic                           clk_out_oe,         // bit/frame clock drivers enabled
    output logic                           data_out_oe,        // data drivers enabled
    output logic                           data_force_zero,    // data held at zero
    output logic                           awake,              // wake-up time elapsed
    output power_cfg_pkg::pwr_state_t      pwr_state,          // current power state
    output power_cfg_pkg::term_t           clk_term,           // bit-clock termination
    output power_cfg_pkg::term_t           frame_term,         // frame-clock termination
    output power_cfg_pkg::term_t           data_term,          // data termination
    output power_cfg_pkg::drive_t          clk_drive,          // bit-clock drive
    output power_cfg_pkg::drive_t          frame_drive,        // frame-clock drive
    output power_cfg_pkg::drive_t          data_drive          // data drive
);
    localparam int LIGHT_WAKE_CYCLES = (`LIGHT_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

    // elaboration checks: four channels are wired in fixed groups, and the
    // wake counter is 16 bits wide and must run at least the short wake time
    if (CHANNELS != 4) begin : g_chan_chk
        $error("CHANNELS must be 4");
    end
    if (DEEP_WAKE_CYCLES < LIGHT_WAKE_CYCLES) begin : g_wake_order_chk
        $error("DEEP_WAKE_CYCLES below the short wake time");
    end
    if (DEEP_WAKE_CYCLES > 65535) begin : g_wake_width_chk
        $error("DEEP_WAKE_CYCLES exceeds the wake counter");
    end

    // termination code decode; code 101 is printed twice and is flagged ambiguous
    function automatic power_cfg_pkg::term_t term_decode(input logic en, input logic [2:0] code);
        power_cfg_pkg::term_t t;
        t = power_cfg_pkg::TERM_OFF;
        if (en) begin
            case (code)
                3'h1:    t = power_cfg_pkg::TERM_260;
                3'h3:    t = power_cfg_pkg::TERM_94;
                3'h4:    t = power_cfg_pkg::TERM_125;
                3'h5:    t = power_cfg_pkg::TERM_AMBIG;
                3'h6:    t = power_cfg_pkg::TERM_66;
                3'h7:    t = power_cfg_pkg::TERM_55;
                default: t = power_cfg_pkg::TERM_OFF;
            endcase
        end
        return t;
    endfunction : term_decode

    // drive code decode; 010 is unprinted and taken as the default current
    function automatic power_cfg_pkg::drive_t drive_decode(input logic [2:0] code);
        power_cfg_pkg::drive_t d;
        case (code)
            3'h1:    d = power_cfg_pkg::DRV_2P5;
            3'h3:    d = power_cfg_pkg::DRV_0P5;
            3'h4:    d = power_cfg_pkg::DRV_7P5;
            3'h5:    d = power_cfg_pkg::DRV_AMBIG;
            3'h6:    d = power_cfg_pkg::DRV_5P5;
            3'h7:    d = power_cfg_pkg::DRV_4P5;
            default: d = power_cfg_pkg::DRV_3P5;
        endcase
        return d;
    endfunction : drive_decode

    // reset release through two flops
    logic rst_sync1_q;
    logic rst_sync2_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync1_q <= 1'b0;
            rst_sync2_q <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_sync2_q <= rst_sync1_q;
        end
    end
    wire rst_n = rst_sync2_q;

    // register storage
    logic [15:0] pwr_q;
    logic [15:0] drive_q;
    logic [15:0] term_q;
    logic [15:0] idle_q;
    logic [15:0] rdata_q;

    wire wr_pwr   = clk_en && reg_wr && (reg_addr == `PWR_STATE_OFS);
    wire wr_drive = clk_en && reg_wr && (reg_addr == `OUT_DRIVE_OFS);
    wire wr_term  = clk_en && reg_wr && (reg_addr == `OUT_TERM_OFS);
    wire wr_idle  = clk_en && reg_wr && (reg_addr == `IDLE_DRV_OFS);

    // register writes; unused bits are not stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_q   <= `PWR_STATE_RST;
            drive_q <= `OUT_DRIVE_RST;
            term_q  <= `OUT_TERM_RST;
            idle_q  <= `IDLE_DRV_RST;
        end else begin
            if (wr_pwr)   pwr_q   <= reg_wdata & 16'h0F7F;
            if (wr_drive) drive_q <= reg_wdata & 16'h0777;
            if (wr_term)  term_q  <= reg_wdata & 16'h4777;
            if (wr_idle)  idle_q  <= reg_wdata & 16'h0001;
        end
    end

    // field extraction
    wire [3:0] quad_channel_sleep   = pwr_q[`QUAD_SLEEP_LSB +: 4];
    wire [1:0] dual_channel_sleep   = pwr_q[`DUAL_SLEEP_LSB +: 2];
    wire       single_channel_sleep = pwr_q[`SINGLE_SLEEP_BIT];
    wire       deep_sleep_bit       = pwr_q[`DEEP_SLEEP_BIT];
    wire       full_power_off       = pwr_q[`FULL_OFF_BIT];
    wire [1:0] idle_pin_function    = pwr_q[`PIN_FUNC_LSB +: 2];
    wire       idle_data_driver_mode = idle_q[`IDLE_MODE_BIT];
    wire       term_en              = term_q[`TERM_EN_BIT];

    // pin request decode, all channels at once
    wire pin_light = idle_request_pin && idle_pin_function[0];
    wire pin_deep  = idle_request_pin && (idle_pin_function == 2'b10);
    wire pin_off   = idle_request_pin && (idle_pin_function == 2'b00);

    // per-channel light sleep from the register fields of all setups
    wire [3:0] reg_chan_sleep = quad_channel_sleep
                              | {dual_channel_sleep[1], dual_channel_sleep[1],
                                 dual_channel_sleep[0], dual_channel_sleep[0]}
                              | {4{single_channel_sleep}};

    wire req_off   = full_power_off || pin_off;
    wire req_deep  = deep_sleep_bit || pin_deep;
    wire req_light = pin_light || (reg_chan_sleep != 4'h0);

    // deepest request wins
    power_cfg_pkg::pwr_state_t state_d;
    assign state_d = req_off   ? power_cfg_pkg::PWR_OFF   :
                     req_deep  ? power_cfg_pkg::PWR_DEEP  :
                     req_light ? power_cfg_pkg::PWR_LIGHT :
                                 power_cfg_pkg::PWR_ACTIVE;

    power_cfg_pkg::pwr_state_t state_q;
    logic [3:0]  chan_q;
    logic [15:0] wake_q;
    logic [15:0] wake_d;

    // wake-up delay: deep sleep and power-off share the long time
    assign wake_d = (state_d != power_cfg_pkg::PWR_ACTIVE) ? 16'h0000 :
                    (state_q == power_cfg_pkg::PWR_DEEP || state_q == power_cfg_pkg::PWR_OFF)
                        ? DEEP_WAKE_CYCLES[15:0] :
                    (state_q == power_cfg_pkg::PWR_LIGHT) ? LIGHT_WAKE_CYCLES[15:0] :
                    (wake_q != 16'h0000) ? wake_q - 16'h0001 : 16'h0000;

    // state, channel sleep and wake counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= power_cfg_pkg::PWR_ACTIVE;
            chan_q  <= 4'h0;
            wake_q  <= 16'h0000;
        end else if (clk_en) begin
            state_q <= state_d;
            chan_q  <= (state_d == power_cfg_pkg::PWR_LIGHT && !pin_light) ? reg_chan_sleep : 4'hF;
            wake_q  <= wake_d;
        end
    end

    wire sleeping = (state_q == power_cfg_pkg::PWR_LIGHT) || (state_q == power_cfg_pkg::PWR_DEEP);

    // outputs of the power state
    assign pwr_state       = state_q;
    assign chan_sleep      = (state_q == power_cfg_pkg::PWR_ACTIVE) ? 4'h0 : chan_q;
    assign ref_power_on    = (state_q != power_cfg_pkg::PWR_OFF);
    assign clk_out_oe      = (state_q != power_cfg_pkg::PWR_OFF);
    assign data_out_oe     = (state_q == power_cfg_pkg::PWR_ACTIVE) ||
                             (sleeping && idle_data_driver_mode);
    assign data_force_zero = sleeping && idle_data_driver_mode;
    assign awake           = (state_q == power_cfg_pkg::PWR_ACTIVE) && (wake_q == 16'h0000);

    // buffer settings
    assign clk_term    = term_decode(term_en, term_q[`CLK_SEL_LSB +: 3]);
    assign frame_term  = term_decode(term_en, term_q[`FRAME_SEL_LSB +: 3]);
    assign data_term   = term_decode(term_en, term_q[`DATA_SEL_LSB +: 3]);
    assign clk_drive   = drive_decode(drive_q[`CLK_SEL_LSB +: 3]);
    assign frame_drive = drive_decode(drive_q[`FRAME_SEL_LSB +: 3]);
    assign data_drive  = drive_decode(drive_q[`DATA_SEL_LSB +: 3]);

    // read mux; unmapped addresses read zero
    wire [15:0] rd_mux = (reg_addr == `PWR_STATE_OFS) ? pwr_q   :
                         (reg_addr == `OUT_DRIVE_OFS) ? drive_q :
                         (reg_addr == `OUT_TERM_OFS)  ? term_q  :
                         (reg_addr == `IDLE_DRV_OFS)  ? idle_q  :
                         (reg_addr == `STATUS_OFS)    ? {9'h000, awake, chan_sleep, state_q} :
                                                        16'h0000;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) rdata_q <= 16'h0000;
        else if (clk_en && reg_rd) rdata_q <= rd_mux;
    end
    assign reg_rdata = rdata_q;

    // checks
    sequence pin_off_req_s;
        idle_request_pin && idle_pin_function == 2'b00;
    endsequence
    sequence off_state_s;
        state_q == power_cfg_pkg::PWR_OFF;
    endsequence

    pin_power_off_a : assert property (@(posedge clk) disable iff (!rst_n)
        pin_off_req_s and clk_en |=> off_state_s) else $error("pin did not power off");
    pin_deep_a : assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && pin_deep && !req_off |=> state_q == power_cfg_pkg::PWR_DEEP) else $error("pin deep fail");
    pin_light_a : assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && pin_light && !req_off && !req_deep |=> chan_sleep == 4'hF) else $error("pin light fail");
    off_clock_hiz_a : assert property (@(posedge clk) disable iff (!rst_n)
        off_state_s |-> !clk_out_oe && !ref_power_on) else $error("clocks driven in power-off");
    sleep_clock_on_a : assert property (@(posedge clk) disable iff (!rst_n)
        sleeping |-> clk_out_oe) else $error("clock stopped in sleep");
    idle_hiz_a : assert property (@(posedge clk) disable iff (!rst_n)
        sleeping && !idle_data_driver_mode |-> !data_out_oe) else $error("data driven in sleep");
    idle_zero_a : assert property (@(posedge clk) disable iff (!rst_n)
        sleeping && idle_data_driver_mode |-> data_out_oe && data_force_zero) else $error("data not zero");
    deep_wake_a : assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && state_q == power_cfg_pkg::PWR_DEEP && state_d == power_cfg_pkg::PWR_ACTIVE
        |=> wake_q == DEEP_WAKE_CYCLES[15:0]) else $error("deep wake time wrong");
    chan_sleep_a : assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && state_d == power_cfg_pkg::PWR_LIGHT && !pin_light |=> chan_sleep == $past(reg_chan_sleep))
        else $error("channel sleep wrong");
    term_off_a : assert property (@(posedge clk) disable iff (!rst_n)
        !term_en |-> clk_term == power_cfg_pkg::TERM_OFF && data_term == power_cfg_pkg::TERM_OFF)
        else $error("termination without enable");
    drive_rst_a : assert property (@(posedge clk) disable iff (!rst_n)
        drive_q == 16'h0000 |-> data_drive == power_cfg_pkg::DRV_3P5) else $error("default drive wrong");
    deepest_a : assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && req_off && req_deep |=> off_state_s) else $error("deepest not chosen");
    term_dec_a : assert property (@(posedge clk) disable iff (!rst_n)
        term_en && term_q[2:0] == 3'h7 |-> clk_term == power_cfg_pkg::TERM_55) else $error("term decode");
    pin_group_a : assert property (@(posedge clk) disable iff (!rst_n)
        chan_sleep != 4'h0 && chan_sleep != 4'hF |-> $past(reg_chan_sleep) != 4'h0)
        else $error("pin split channels");

    // wake-up: leaving a sleep state loads the counter, then it runs down to zero
    sequence deep_exit_s;
        clk_en && state_d == power_cfg_pkg::PWR_ACTIVE
            && (state_q == power_cfg_pkg::PWR_DEEP || state_q == power_cfg_pkg::PWR_OFF);
    endsequence
    sequence light_exit_s;
        clk_en && state_d == power_cfg_pkg::PWR_ACTIVE && state_q == power_cfg_pkg::PWR_LIGHT;
    endsequence
    sequence waking_s;
        state_q == power_cfg_pkg::PWR_ACTIVE && !awake;
    endsequence

    off_wake_a : assert property (@(posedge clk) disable iff (!rst_n)
        deep_exit_s |=> waking_s ##0 (wake_q == DEEP_WAKE_CYCLES[15:0]))
        else $error("long wake time wrong");

    light_wake_a : assert property (@(posedge clk) disable iff (!rst_n)
        light_exit_s |=> waking_s ##0 (wake_q == LIGHT_WAKE_CYCLES[15:0]))
        else $error("short wake time wrong");

    wake_count_a : assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && state_q == power_cfg_pkg::PWR_ACTIVE && state_d == power_cfg_pkg::PWR_ACTIVE
        && wake_q != 16'h0000 |=> wake_q == $past(wake_q) - 16'h0001)
        else $error("wake counter skipped");

    // clock enable low holds the power state and the wake counter
    freeze_hold_a : assert property (@(posedge clk) disable iff (!rst_n)
        !clk_en |=> state_q == $past(state_q) && wake_q == $past(wake_q))
        else $error("state moved with clock enable low");

    // register-driven entries into off, deep and light, pin priority over the register, and active-state outputs
    reg_power_off_a : assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && full_power_off |=> off_state_s ##0 (!ref_power_on))
        else $error("power-off bit ignored");

    deep_bit_a : assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && deep_sleep_bit && !req_off |=> state_q == power_cfg_pkg::PWR_DEEP && clk_out_oe)
        else $error("deep sleep bit ignored");

    reg_light_a : assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && reg_chan_sleep != 4'h0 && !req_off && !req_deep
        |=> state_q == power_cfg_pkg::PWR_LIGHT && clk_out_oe && ref_power_on)
        else $error("channel sleep bits ignored");

    pin_over_reg_a : assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && pin_light && reg_chan_sleep != 4'h0 && !req_off && !req_deep |=> chan_sleep == 4'hF)
        else $error("pin did not sleep every channel");

    active_data_a : assert property (@(posedge clk) disable iff (!rst_n)
        state_q == power_cfg_pkg::PWR_ACTIVE |-> data_out_oe && !data_force_zero && chan_sleep == 4'h0)
        else $error("data path idle while active");

    // decode spot checks on the frame and data selectors
    term_frame_a : assert property (@(posedge clk) disable iff (!rst_n)
        term_en && term_q[`FRAME_SEL_LSB +: 3] == 3'h1 |-> frame_term == power_cfg_pkg::TERM_260)
        else $error("frame termination decode");

    term_data_a : assert property (@(posedge clk) disable iff (!rst_n)
        term_en && term_q[`DATA_SEL_LSB +: 3] == 3'h6 |-> data_term == power_cfg_pkg::TERM_66)
        else $error("data termination decode");

    drive_data_a : assert property (@(posedge clk) disable iff (!rst_n)
        drive_q[`DATA_SEL_LSB +: 3] == 3'h4 |-> data_drive == power_cfg_pkg::DRV_7P5)
        else $error("data drive decode");

    drive_frame_a : assert property (@(posedge clk) disable iff (!rst_n)
        drive_q[`FRAME_SEL_LSB +: 3] == 3'h3 |-> frame_drive == power_cfg_pkg::DRV_0P5)
        else $error("frame drive decode");

    // register port: read data are the register as it stood at the strobe
    read_back_a : assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && reg_rd && reg_addr == `PWR_STATE_OFS |=> reg_rdata == $past(pwr_q))
        else $error("power register read-back");

    status_read_a : assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && reg_rd && reg_addr == `STATUS_OFS |=> reg_rdata[1:0] == $past(state_q))
        else $error("status read-back");
endmodule : power_mode_ctrl
`default_nettype wire

// file: shared/power_cfg_params.svh
// register offsets, field positions, reset values, wake times and clock period for the power/output control block
`ifndef POWER_CFG_PARAMS_SVH
`define POWER_CFG_PARAMS_SVH
`define PWR_STATE_OFS       8'h0F
`define OUT_DRIVE_OFS       8'h11
`define OUT_TERM_OFS        8'h12
`define IDLE_DRV_OFS        8'h52
`define STATUS_OFS          8'h60
`define QUAD_SLEEP_LSB      0
`define DUAL_SLEEP_LSB      4
`define SINGLE_SLEEP_BIT    6
`define DEEP_SLEEP_BIT      8
`define FULL_OFF_BIT        9
`define PIN_FUNC_LSB        10
`define TERM_EN_BIT         14
`define CLK_SEL_LSB         0
`define FRAME_SEL_LSB       4
`define DATA_SEL_LSB        8
`define IDLE_MODE_BIT       0
`define PWR_STATE_RST       16'h0000
`define OUT_DRIVE_RST       16'h0000
`define OUT_TERM_RST        16'h0000
`define IDLE_DRV_RST        16'h0000
`define LIGHT_WAKE_NS       500
`define DEEP_WAKE_NS        15000
`define CLK_PERIOD_NS       8
`endif

// file: shared/power_cfg_pkg.sv
// types for the power/output control block
`default_nettype none
package power_cfg_pkg;
    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'b00,
        PWR_LIGHT  = 2'b01,
        PWR_DEEP   = 2'b10,
        PWR_OFF    = 2'b11
    } pwr_state_t;

    typedef enum logic [3:0] {
        TERM_OFF   = 4'h0,
        TERM_260   = 4'h1,
        TERM_94    = 4'h2,
        TERM_125   = 4'h3,
        TERM_66    = 4'h4,
        TERM_55    = 4'h5,
        TERM_AMBIG = 4'hF
    } term_t;

    typedef enum logic [3:0] {
        DRV_3P5    = 4'h0,
        DRV_2P5    = 4'h1,
        DRV_0P5    = 4'h2,
        DRV_7P5    = 4'h3,
        DRV_5P5    = 4'h4,
        DRV_4P5    = 4'h5,
        DRV_AMBIG  = 4'hF
    } drive_t;
endpackage : power_cfg_pkg
`default_nettype wire

// file: test/idle_host_model.sv
// host-side driver of the idle-request pin
`timescale 1ns/1ns
`default_nettype none
module idle_host_model (
    input  wire logic clk,              // system clock
    input  wire logic request,          // bench asks for idle
    output logic      idle_request_pin  // level toward the block
);
    // the pin moves only just after a rising edge, so the block samples a settled level
    always_ff @(posedge clk) begin
        idle_request_pin <= request;
    end
endmodule : idle_host_model
`default_nettype wire

// file: test/tb_power_mode_ctrl.sv
// self-checking bench for the power-mode and output configuration block
`timescale 1ns/1ns
`default_nettype none
`include "power_cfg_params.svh"
module tb_power_mode_ctrl;
    logic                       clk       = 1'b0;
    logic                       rst_b     = 1'b0;
    logic [7:0]                 reg_addr  = 8'h00;
    logic [15:0]                reg_wdata = 16'h0000;
    logic                       reg_wr    = 1'b0;
    logic                       reg_rd    = 1'b0;
    logic                       pin_req   = 1'b0;
    logic                       clk_en    = 1'b1;
    logic                       idle_request_pin;
    logic [15:0]                reg_rdata;
    logic [3:0]                 chan_sleep;
    logic                       ref_power_on, clk_out_oe, data_out_oe, data_force_zero, awake;
    power_cfg_pkg::pwr_state_t  pwr_state;
    power_cfg_pkg::term_t       clk_term, frame_term, data_term;
    power_cfg_pkg::drive_t      clk_drive, frame_drive, data_drive;
    int                         n_mismatch   = 0;
    int                         total_checks = 0;
    int                         deep_cnt, off_cnt, tmp_cnt;
    logic [15:0]                rd_q;
    localparam int              DEEP_SIM  = 100;  // long wake, above the short wake count
    localparam int              LIGHT_SIM = (`LIGHT_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam logic [2:0] CODES [6] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h6, 3'h7};
    localparam power_cfg_pkg::term_t TERMS [6] = '{power_cfg_pkg::TERM_OFF, power_cfg_pkg::TERM_260,
        power_cfg_pkg::TERM_94, power_cfg_pkg::TERM_125, power_cfg_pkg::TERM_66, power_cfg_pkg::TERM_55};
    localparam power_cfg_pkg::drive_t DRVS [6] = '{power_cfg_pkg::DRV_3P5, power_cfg_pkg::DRV_2P5,
        power_cfg_pkg::DRV_0P5, power_cfg_pkg::DRV_7P5, power_cfg_pkg::DRV_5P5, power_cfg_pkg::DRV_4P5};

    // reduced long wake count keeps the run brief
    power_mode_ctrl #(.CHANNELS(4), .DEEP_WAKE_CYCLES(DEEP_SIM)) power_mode_ctrl_inst (
        .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .idle_request_pin(idle_request_pin),
        .chan_sleep(chan_sleep), .ref_power_on(ref_power_on), .clk_out_oe(clk_out_oe),
        .data_out_oe(data_out_oe), .data_force_zero(data_force_zero), .awake(awake),
        .pwr_state(pwr_state), .clk_term(clk_term), .frame_term(frame_term), .data_term(data_term),
        .clk_drive(clk_drive), .frame_drive(frame_drive), .data_drive(data_drive));
    idle_host_model idle_host_model_inst (.clk(clk), .request(pin_req), .idle_request_pin(idle_request_pin));

    // 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        rd_q = reg_rdata;
    endtask : rd

    // counts cycles until the block reports itself awake, bounded
    task automatic wait_awake(output int cnt);
        cnt = 0;
        while (awake !== 1'b1) begin
            settle(1);
            cnt++;
            if (cnt > 300) begin
                n_mismatch++;
                stop_test();
            end
        end
    endtask : wait_awake

    // reset values, unused bits and an unmapped address
    task automatic t_reset();
        clk_en <= 1'b0;
        wr(`PWR_STATE_OFS, 16'h0200);
        clk_en <= 1'b1;
        rd(`PWR_STATE_OFS);
        chk("pwr reg", rd_q, `PWR_STATE_RST);
        rd(`OUT_TERM_OFS);
        chk("term reg", rd_q, `OUT_TERM_RST);
        chk("clk drive", clk_drive, power_cfg_pkg::DRV_3P5);
        chk("state", pwr_state, power_cfg_pkg::PWR_ACTIVE);
        wr(`IDLE_DRV_OFS, 16'hFFFF);
        rd(`IDLE_DRV_OFS);
        chk("idle reg", rd_q, 16'h0001);
        wr(8'h20, 16'hFFFF);
        rd(8'h20);
        chk("unmapped", rd_q, 16'h0000);
        wr(`IDLE_DRV_OFS, 16'h0000);
    endtask : t_reset

    // six codes on each selector, then 101 on clk and 010 on frame; fields set apart so they must be independent
    task automatic t_term();
        logic [15:0] w;
        for (int i = 0; i < 6; i++) begin
            w = (16'(CODES[(i + 2) % 6]) << 8) | (16'(CODES[(i + 1) % 6]) << 4) | 16'(CODES[i]);
            wr(`OUT_TERM_OFS, w | 16'h4000);
            wr(`OUT_DRIVE_OFS, w);
            settle(1);
            chk("clk term", clk_term, TERMS[i]);
            chk("frame term", frame_term, TERMS[(i + 1) % 6]);
            chk("data term", data_term, TERMS[(i + 2) % 6]);
            chk("clk drive", clk_drive, DRVS[i]);
            chk("frame drive", frame_drive, DRVS[(i + 1) % 6]);
            chk("data drive", data_drive, DRVS[(i + 2) % 6]);
        end
        wr(`OUT_TERM_OFS, 16'h4225);
        wr(`OUT_DRIVE_OFS, 16'h0025);
        settle(1);
        chk("ambig term", clk_term, power_cfg_pkg::TERM_AMBIG);
        chk("unused term", frame_term, power_cfg_pkg::TERM_OFF);
        chk("ambig drive", clk_drive, power_cfg_pkg::DRV_AMBIG);
        chk("unused drive", frame_drive, power_cfg_pkg::DRV_3P5);
        wr(`OUT_TERM_OFS, 16'h0777);
        settle(1);
        chk("term disabled", clk_term, power_cfg_pkg::TERM_OFF);
    endtask : t_term

    // one channel at a time into light sleep, data drivers off, clocks on
    task automatic t_light();
        for (int n = 0; n < 4; n++) begin
            wr(`PWR_STATE_OFS, 16'h0001 << n);
            settle(2);
            chk("chan sleep", chan_sleep, 4'h1 << n);
            chk("light state", pwr_state, power_cfg_pkg::PWR_LIGHT);
            chk("data oe light", data_out_oe, 1'b0);
            chk("clk oe light", clk_out_oe, 1'b1);
        end
        rd(`STATUS_OFS);
        chk("status", rd_q, 16'h0021);
        wr(`PWR_STATE_OFS, 16'h0000);
        wait_awake(tmp_cnt);
        chk("light wake", 16'(tmp_cnt), 16'(LIGHT_SIM + 1));
    endtask : t_light

    // deep sleep with drivers held at zero, then power-off; both wake times compared
    task automatic t_deep_off();
        wr(`IDLE_DRV_OFS, 16'h0001);
        wr(`PWR_STATE_OFS, 16'h0100);
        settle(2);
        chk("deep state", pwr_state, power_cfg_pkg::PWR_DEEP);
        chk("clk oe deep", clk_out_oe, 1'b1);
        chk("data oe deep", data_out_oe, 1'b1);
        chk("data zero", data_force_zero, 1'b1);
        wr(`IDLE_DRV_OFS, 16'h0000);
        settle(1);
        chk("data oe mode0", data_out_oe, 1'b0);
        wr(`PWR_STATE_OFS, 16'h0000);
        wait_awake(deep_cnt);
        wr(`PWR_STATE_OFS, 16'h0200);
        settle(2);
        chk("off state", pwr_state, power_cfg_pkg::PWR_OFF);
        chk("clk oe off", clk_out_oe, 1'b0);
        chk("ref off", ref_power_on, 1'b0);
        wr(`PWR_STATE_OFS, 16'h0000);
        wait_awake(off_cnt);
        chk("deep wake", 16'(deep_cnt), 16'(off_cnt));
        chk("long wake", 16'(off_cnt), 16'(DEEP_SIM + 1));
    endtask : t_deep_off

    // each pin function, then a register request mixed with the pin
    task automatic t_pin();
        power_cfg_pkg::pwr_state_t exp;
        for (int f = 0; f < 5; f++) begin
            exp = (f == 0) ? power_cfg_pkg::PWR_OFF : (f == 2) ? power_cfg_pkg::PWR_DEEP :
                  (f == 4) ? power_cfg_pkg::PWR_DEEP : power_cfg_pkg::PWR_LIGHT;
            wr(`PWR_STATE_OFS, (f == 4) ? 16'h0801 : (f == 3) ? 16'h0C01 : 16'(f) << 10);
            pin_req <= 1'b1;
            settle(4);
            chk("pin state", pwr_state, exp);
            chk("pin chans", chan_sleep, 4'hF);
            @(posedge clk);
            pin_req <= 1'b0;
            wr(`PWR_STATE_OFS, 16'h0000);
            settle(2);
            wait_awake(tmp_cnt);
        end
    endtask : t_pin

    // reset, then the scenarios in turn
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_term();
        t_light();
        t_deep_off();
        t_pin();
        stop_test();
    end
endmodule : tb_power_mode_ctrl
`default_nettype wire
